/* shared/capture_trigger_map.vh */
// Register offsets, field positions and reset values of the capture trigger block
`ifndef CAPTURE_TRIGGER_MAP_VH
`define CAPTURE_TRIGGER_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define CT_OFF_CONTROL 12'h000
`define CT_OFF_IRQ_STATUS 12'h004
`define CT_OFF_IRQ_MASK 12'h008
`define CT_OFF_TIMER 12'h00C

// ****************************************
// Control register fields
// ****************************************
`define CT_BIT_CASCADE 8
`define CT_BIT_TRIG_MODE 7
`define CT_BIT_TRIG_STATUS 6
`define CT_SEL_MSB 4
`define CT_SEL_LSB 0
`define CT_CONTROL_RESET 16'h000D
`define CT_CONTROL_WMASK 16'h01DF

// ****************************************
// Interrupt status fields
// ****************************************
`define CT_IRQ_TRIGGER 0
`define CT_IRQ_SYNC 1
`define CT_IRQ_WRAP 2
`define CT_IRQ_WIDTH 3
`define CT_IRQ_RESET 3'h0

// ****************************************
// Source selector codes
// ****************************************
`define CT_SEL_NONE 5'h00
`define CT_SEL_SEQUENCER 5'h1F

`endif

/* verilog/capture_timer.v */
// Capture timer, 16 bits alone or 32 bits when cascaded
`timescale 1ns/1ps
`default_nettype none

module capture_timer (
	// Clock and reset
	input wire mclk_in,
	input wire reset_in,
	// Control
	input wire clear_in,
	input wire run_in,
	input wire wide_in,
	// State
	output reg [31:0] count_out,
	output wire wrap_out
);

	// Terminal count depends on width
	assign wrap_out = run_in && !clear_in &&
		(wide_in ? (count_out == 32'hFFFFFFFF) : (count_out[15:0] == 16'hFFFF));

	// Count, clear takes priority, upper half held at zero when not wide
	always @(posedge mclk_in) begin
		if (reset_in || clear_in) begin
			count_out <= 32'h00000000;
		end else if (run_in) begin
			if (wide_in) begin
				count_out <= count_out + 32'h00000001;
			end else begin
				count_out <= {16'h0000, count_out[15:0] + 16'h0001};
			end
		end else if (!wide_in) begin
			count_out <= {16'h0000, count_out[15:0]};
		end
	end

endmodule

`default_nettype wire

/* verilog/capture_trigger_sync_control.v */
// Trigger, synchronization and cascade control of one capture unit
//
// Function
// - Cascade bit one pairs units into 32 bits
// - Cascade bit zero keeps units independent
// - Cascade needs the bit in both units
// - Trigger mode: selected source starts timer
// - Sync mode: source synchronizes timer to another
// - Status flag one while timer triggered, running
// - Selected source event sets status flag
// - Software reads, sets, clears flag alongside hardware
// - Five bit selector picks the source
// - Bits 15 to 9 and 5 read zero
// - One selector code for the trigger sequencer
`timescale 1ns/1ps
`default_nettype none
`include "capture_trigger_map.vh"

module capture_trigger_sync_control #(
	parameter [4:0] UNIT_INDEX = 5'h01
) (
	// Clock and reset
	input wire mclk_in,
	input wire reset_in,
	// APB slave
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	output wire pready_out,
	output reg [31:0] prdata_out,
	output reg pslverr_out,
	// Paired unit and sources
	input wire partner_cascade_in,
	input wire [30:1] source_event_in,
	input wire sequencer_trigger_in,
	// Block state
	output wire cascade_select_out,
	output wire cascade_active_out,
	output reg trigger_status_flag_out,
	output wire [31:0] capture_timer_out,
	output wire irq_out
);

	// ****************************************
	// Declarations
	// ****************************************
	reg cascade_select;
	reg trigger_mode_select;
	reg [4:0] source_selector;
	reg [`CT_IRQ_WIDTH-1:0] irq_status;
	reg [`CT_IRQ_WIDTH-1:0] irq_mask;
	reg ack;
	wire access;
	wire wr_commit;
	wire ctrl_wr;
	wire source_hit;
	wire timer_clear;
	wire timer_run;
	wire timer_wrap;
	wire addr_known;
	reg next_status;
	reg [`CT_IRQ_WIDTH-1:0] next_irq;
	wire [`CT_IRQ_WIDTH-1:0] irq_events;
	wire [15:0] control_view;
	wire status_wr;
	wire mask_wr;
	wire trigger_event;
	wire sync_event;

	// Reset view of the control register, sliced field by field so that
	// every reset load takes exactly the bits of its own field
	localparam [15:0] CONTROL_RESET = `CT_CONTROL_RESET;

	// ****************************************
	// Helper functions
	// ****************************************

	// Pick the event of the source named by the selector
	function pick_source;
		input [4:0] sel;
		input [30:1] events;
		input seq;
		begin
			if (sel == `CT_SEL_NONE) begin
				pick_source = 1'b0;
			end else if (sel == UNIT_INDEX) begin
				pick_source = 1'b0;
			end else if (sel == `CT_SEL_SEQUENCER) begin
				pick_source = seq;
			end else begin
				pick_source = events[sel];
			end
		end
	endfunction

	// Write strobe for one mapped register, refused on a bus error
	function reg_write;
		input commit;
		input err;
		input [11:0] addr;
		input [11:0] target;
		begin
			reg_write = commit && !err && (addr == target);
		end
	endfunction

	// Decode a byte address into a known register
	function addr_hit;
		input [11:0] addr;
		begin
			if (addr == `CT_OFF_CONTROL) begin
				addr_hit = 1'b1;
			end else if (addr == `CT_OFF_IRQ_STATUS) begin
				addr_hit = 1'b1;
			end else if (addr == `CT_OFF_IRQ_MASK) begin
				addr_hit = 1'b1;
			end else if (addr == `CT_OFF_TIMER) begin
				addr_hit = 1'b1;
			end else begin
				addr_hit = 1'b0;
			end
		end
	endfunction

	// ****************************************
	// APB handshake
	// ****************************************

	// One wait state: read data is registered before pready rises
	// The extra cycle keeps the read mux out of the prdata timing path,
	// at the cost of one cycle per transfer
	assign access = psel_in && penable_in;
	assign pready_out = ack;
	assign wr_commit = access && ack && pwrite_in;
	assign addr_known = addr_hit(paddr_in);

	// Per-register write strobes, all at the pready edge only
	assign ctrl_wr = reg_write(wr_commit, pslverr_out, paddr_in, `CT_OFF_CONTROL);
	assign status_wr = reg_write(wr_commit, pslverr_out, paddr_in, `CT_OFF_IRQ_STATUS);
	assign mask_wr = reg_write(wr_commit, pslverr_out, paddr_in, `CT_OFF_IRQ_MASK);

	// Ready pulses for one cycle after the first access cycle
	always @(posedge mclk_in) begin
		if (reset_in) begin
			ack <= 1'b0;
		end else begin
			ack <= access && !ack;
		end
	end

	// Error flag for unmapped addresses, valid with pready
	always @(posedge mclk_in) begin
		if (reset_in) begin
			pslverr_out <= 1'b0;
		end else if (access && !ack) begin
			pslverr_out <= !addr_known;
		end else begin
			pslverr_out <= 1'b0;
		end
	end

	// ****************************************
	// Control register
	// ****************************************

	// Reserved bits tie to zero in the read view
	assign control_view = {7'h00, cascade_select, trigger_mode_select,
		trigger_status_flag_out, 1'b0, source_selector};

	// Writable control fields
	always @(posedge mclk_in) begin
		if (reset_in) begin
			cascade_select <= CONTROL_RESET[`CT_BIT_CASCADE];
			trigger_mode_select <= CONTROL_RESET[`CT_BIT_TRIG_MODE];
			source_selector <= CONTROL_RESET[`CT_SEL_MSB:`CT_SEL_LSB];
		end else if (ctrl_wr) begin
			cascade_select <= pwdata_in[`CT_BIT_CASCADE];
			trigger_mode_select <= pwdata_in[`CT_BIT_TRIG_MODE];
			source_selector <= pwdata_in[`CT_SEL_MSB:`CT_SEL_LSB];
		end
	end

	// Cascade only when both halves of the pair agree
	assign cascade_select_out = cascade_select;
	assign cascade_active_out = cascade_select && partner_cascade_in;

	// ****************************************
	// Trigger status flag
	// ****************************************

	// Event from the chosen source
	assign source_hit = pick_source(source_selector, source_event_in,
		sequencer_trigger_in);

	// Software write first, hardware set wins
	// A clear that meets an event in one cycle loses, so no trigger is lost
	always @* begin
		next_status = trigger_status_flag_out;
		if (ctrl_wr) begin
			next_status = pwdata_in[`CT_BIT_TRIG_STATUS];
		end
		if (source_hit) begin
			next_status = 1'b1;
		end
	end

	// Flag register
	always @(posedge mclk_in) begin
		if (reset_in) begin
			trigger_status_flag_out <= 1'b0;
		end else begin
			trigger_status_flag_out <= next_status;
		end
	end

	// ****************************************
	// Capture timer control
	// ****************************************

	// Trigger mode: run only while the flag is set, else held clear
	// Sync mode: free-run, zero on every source event
	assign timer_run = trigger_mode_select ? trigger_status_flag_out : 1'b1;
	assign timer_clear = trigger_mode_select ? !trigger_status_flag_out
		: source_hit;

	// Timer core, width follows the pair state
	capture_timer u_timer (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.clear_in(timer_clear),
		.run_in(timer_run),
		.wide_in(cascade_active_out),
		.count_out(capture_timer_out),
		.wrap_out(timer_wrap)
	);

	// ****************************************
	// Interrupts
	// ****************************************

	// Source events split by the mode that is in force
	assign trigger_event = source_hit && trigger_mode_select;
	assign sync_event = source_hit && !trigger_mode_select;

	// Events: trigger taken, sync reset, timer wrap
	assign irq_events = {timer_wrap, sync_event, trigger_event};

	// Write one clears, new event wins
	always @* begin
		next_irq = irq_status;
		if (status_wr) begin
			next_irq = irq_status & ~pwdata_in[`CT_IRQ_WIDTH-1:0];
		end
		next_irq = next_irq | irq_events;
	end

	// Status and mask registers
	always @(posedge mclk_in) begin
		if (reset_in) begin
			irq_status <= `CT_IRQ_RESET;
			irq_mask <= `CT_IRQ_RESET;
		end else begin
			irq_status <= next_irq;
			if (mask_wr) begin
				irq_mask <= pwdata_in[`CT_IRQ_WIDTH-1:0];
			end
		end
	end

	// Level output while any unmasked bit is set
	assign irq_out = |(irq_status & irq_mask);

	// ****************************************
	// Read data
	// ****************************************

	// Capture read data in the first access cycle
	always @(posedge mclk_in) begin
		if (reset_in) begin
			prdata_out <= 32'h00000000;
		end else if (access && !ack && !pwrite_in) begin
			if (paddr_in == `CT_OFF_CONTROL) begin
				prdata_out <= {16'h0000, control_view};
			end else if (paddr_in == `CT_OFF_IRQ_STATUS) begin
				prdata_out <= {29'h00000000, irq_status};
			end else if (paddr_in == `CT_OFF_IRQ_MASK) begin
				prdata_out <= {29'h00000000, irq_mask};
			end else if (paddr_in == `CT_OFF_TIMER) begin
				prdata_out <= capture_timer_out;
			end else begin
				prdata_out <= 32'h00000000;
			end
		end
	end

endmodule

`default_nettype wire

/* bench/capture_trigger_monitor.sv */
// Port checker of the capture trigger block
`timescale 1ns/1ps
`default_nettype none
module capture_trigger_monitor #(
	parameter [4:0] UNIT_INDEX = 5'h01
) (
	// Clock and reset
	input wire mclk_in,
	input wire reset_in,
	// Bus
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire pready_out,
	// Sources and state
	input wire partner_cascade_in,
	input wire [30:1] source_event_in,
	input wire sequencer_trigger_in,
	input wire cascade_select_out,
	input wire cascade_active_out,
	input wire trigger_status_flag_out,
	input wire [31:0] capture_timer_out
);
	logic mode;
	logic [4:0] sel;
	wire flag = trigger_status_flag_out;
	wire [31:0] tmr = capture_timer_out;
	wire top = tmr[15:0] == 16'hFFFF;
	wire wr = psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h000;
	wire ev = (sel == 5'h1F) ? sequencer_trigger_in :
		(sel != 5'h00 && sel != UNIT_INDEX && source_event_in[sel]);
	// Shadow of mode and selector, loaded by control writes
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			mode <= 1'h0;
			sel <= 5'h0D;
		end else if (wr) begin
			mode <= pwdata_in[7];
			sel <= pwdata_in[4:0];
		end
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	// Pairing, bus answer and flag
	property p_cascade; cascade_active_out == (cascade_select_out && partner_cascade_in); endproperty
	a_cascade: assert property (p_cascade) else $error("cascade");
	property p_ready; psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out; endproperty
	a_ready: assert property (p_ready) else $error("ready");
	property p_soft; wr |=> flag == ($past(pwdata_in[6]) || $past(ev)); endproperty
	a_soft: assert property (p_soft) else $error("flag write");
	property p_set; ev |=> flag; endproperty
	a_set: assert property (p_set) else $error("flag set");
	// Timer in both modes
	property p_hold; mode && $past(mode) && !flag && !$past(flag) |-> tmr == 32'h0; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_count;
		mode && $past(mode) && $past(flag) && $past(flag, 2) && !$past(top) |-> tmr == $past(tmr) + 32'h1;
	endproperty
	a_count: assert property (p_count) else $error("count");
	property p_sync; !mode && ev |=> tmr == 32'h0; endproperty
	a_sync: assert property (p_sync) else $error("sync");
	property p_free;
		!mode && !$past(mode) && !$past(ev) && !$past(top) && !$past(wr) && !$past(reset_in)
			|-> tmr == $past(tmr) + 32'h1;
	endproperty
	a_free: assert property (p_free) else $error("free run");
	c_trig: cover property (mode && ev);
	c_sync: cover property (!mode && ev);
	c_pair: cover property (cascade_active_out);
endmodule
`default_nettype wire

/* bench/trigger_source_model.sv */
// Source lines of the neighbouring trigger and sync modules
`timescale 1ns/1ps
`default_nettype none
module trigger_source_model (
	// Command
	input wire logic fire_in,
	input wire logic [4:0] code_in,
	input wire logic cascade_in,
	// Lines into the unit
	output wire logic [30:1] source_event_out,
	output wire logic sequencer_trigger_out,
	output wire logic partner_cascade_out
);
	wire [31:0] hot = fire_in ? 32'h1 << code_in : 32'h0;
	// One line per code, the top code from the sequencer
	assign source_event_out = hot[30:1];
	assign sequencer_trigger_out = hot[31];
	assign partner_cascade_out = cascade_in;
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench of the capture trigger block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk_in = 1'h0, reset_in = 1'h1, psel_in = 1'h0, penable_in = 1'h0;
	logic pwrite_in = 1'h0, fire = 1'h0, cascade = 1'h0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0, rd;
	logic err;
	logic [4:0] code = 5'h00;
	wire pready_out, pslverr_out, cascade_select_out, cascade_active_out, irq_out;
	wire trigger_status_flag_out, partner_cascade_in, sequencer_trigger_in;
	wire [31:0] prdata_out, capture_timer_out;
	wire [30:1] source_event_in;
	int n_errors = 0, checks = 0;
	// Clock
	always #2 mclk_in = ~mclk_in;
	// Block and its sources
	capture_trigger_sync_control u_capture_trigger_sync_control (.mclk_in, .reset_in, .psel_in,
		.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out,
		.partner_cascade_in, .source_event_in, .sequencer_trigger_in, .cascade_select_out,
		.cascade_active_out, .trigger_status_flag_out, .capture_timer_out, .irq_out);
	trigger_source_model u_trigger_source_model (.fire_in(fire), .code_in(code),
		.cascade_in(cascade), .source_event_out(source_event_in),
		.sequencer_trigger_out(sequencer_trigger_in), .partner_cascade_out(partner_cascade_in));
	// Compare and count
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// One bus transfer, then one idle edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge mclk_in);
		psel_in <= 1'h1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1'h1;
		do @(posedge mclk_in); while (pready_out !== 1'h1 && ++t < 20);
		if (pready_out !== 1'h1) begin
			n_errors++;
			$display("[FAIL] pready expected 1 seen %h", pready_out);
		end
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
		@(posedge mclk_in);
	endtask
	// One-cycle event on source c
	task automatic pulse(input logic [4:0] c);
		@(posedge mclk_in);
		code <= c;
		fire <= 1'h1;
		@(posedge mclk_in);
		fire <= 1'h0;
		@(posedge mclk_in);
	endtask
	// Reset value, unmapped place, cascade pairing
	task t_cascade;
		apb(1'h0, 12'h000, 32'h0);
		chk("control", 32'h0000000D, rd);
		apb(1'h0, 12'h010, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("slverr", 32'h1, 32'(err));
		cascade <= 1'h1;
		@(posedge mclk_in);
		chk("alone", 32'h0, 32'(cascade_active_out));
		apb(1'h1, 12'h000, 32'h0000FFFF);
		apb(1'h0, 12'h000, 32'h0);
		chk("control", 32'h000001DF, rd);
		chk("pair", 32'h1, 32'(cascade_active_out));
		cascade <= 1'h0;
		@(posedge mclk_in);
		chk("one side", 32'h0, 32'(cascade_active_out));
	endtask
	// Trigger mode: only the selected source sets the flag
	task t_trigger;
		apb(1'h1, 12'h000, 32'h00000082);
		repeat (2) @(posedge mclk_in);
		chk("held", 32'h0, capture_timer_out);
		pulse(5'h03);
		chk("other", 32'h0, 32'(trigger_status_flag_out));
		pulse(5'h02);
		chk("selected", 32'h1, 32'(trigger_status_flag_out));
		apb(1'h1, 12'h000, 32'h0000009F);
		chk("cleared", 32'h0, 32'(trigger_status_flag_out));
		pulse(5'h1F);
		chk("sequencer", 32'h1, 32'(trigger_status_flag_out));
	endtask
	// Sync mode, interrupt raised, cleared and masked
	task t_sync;
		apb(1'h1, 12'h008, 32'h3);
		chk("irq", 32'h1, 32'(irq_out));
		apb(1'h1, 12'h004, 32'h3);
		chk("irq clear", 32'h0, 32'(irq_out));
		apb(1'h1, 12'h000, 32'h00000002);
		pulse(5'h02);
		chk("synced", 32'h0, capture_timer_out);
		repeat (4) @(posedge mclk_in);
		chk("free run", 32'h4, capture_timer_out);
		apb(1'h0, 12'h004, 32'h0);
		chk("sync event", 32'h2, rd & 32'h2);
		apb(1'h1, 12'h008, 32'h0);
		chk("masked", 32'h0, 32'(irq_out));
	endtask
	// Verdict
	task end_of_test;
		if (n_errors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge mclk_in);
		reset_in <= 1'h0;
		t_cascade;
		t_trigger;
		t_sync;
		end_of_test;
	end
	// Watchdog
	initial begin
		#20000;
		n_errors++;
		end_of_test;
	end
endmodule
bind capture_trigger_sync_control capture_trigger_monitor #(.UNIT_INDEX(UNIT_INDEX))
	u_capture_trigger_monitor (.mclk_in, .reset_in, .psel_in, .penable_in, .pwrite_in,
	.paddr_in, .pwdata_in, .pready_out, .partner_cascade_in, .source_event_in,
	.sequencer_trigger_in, .cascade_select_out, .cascade_active_out, .trigger_status_flag_out,
	.capture_timer_out);
`default_nettype wire
